// *** power_state_pkg.sv ***
/*
 * power_state_pkg: shared types and constants for the drive power-state
 * controller. Assumes a single 250 MHz clock domain.
 */
package power_state_pkg;

  // power consumption states, 2-bit encoding reported to the host
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_IDLE,
    PWR_STANDBY,
    PWR_SLEEP
  } power_state_e;

  // command classes decoded by the host command front end
  typedef enum logic [2:0] {
    CMD_IDLE,
    CMD_IDLE_IMMEDIATE,
    CMD_STANDBY,
    CMD_STANDBY_IMMEDIATE,
    CMD_SLEEP,
    CMD_CHECK_POWER_MODE,
    CMD_MEDIA,
    CMD_NON_MEDIA
  } cmd_kind_e;

  // one host command offered to the controller
  typedef struct packed {
    logic valid;
    cmd_kind_e kind;
  } host_cmd_s;

  // result handed back for an accepted or ignored command
  typedef struct packed {
    logic done;
    logic ignored;
    power_state_e state;
  } cmd_resp_s;

  // drive power gating outputs
  typedef struct packed {
    logic voice_coil_driver_on;
    logic spindle_on;
  } power_gate_s;

  localparam int TIMER_WIDTH = 32;
  localparam logic [TIMER_WIDTH-1:0] TIMER_RESET = 32'h0000_0000;
  // spin-up delay before a media command may run from standby
  localparam int SPINUP_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SPINUP_CYCLES =
      (SPINUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // voice-coil reload delay before a media command may run from idle
  localparam int LOAD_NS = 200;
  localparam int LOAD_CYCLES = (LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WIDTH = 16;

endpackage : power_state_pkg

// *** inactivity_timer.sv ***
/*
 * inactivity_timer: automatic power-down counter.
 * Assumes restart and run come from logic on the same clock.
 */
`timescale 1ns/1ns
module inactivity_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic enable_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic [WIDTH-1:0] limit_in,
  // status
  output logic expired_out
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic at_limit;

  assign at_limit = (count_q >= limit_in);
  assign count_d = (restart_in || !run_in || !enable_in) ? '0 :
                   at_limit ? count_q : count_q + 1'b1;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
      expired_out <= 1'b0;
    end else begin
      count_q <= count_d;
      // a pending restart wins over an expiry in the same cycle
      expired_out <= enable_in && run_in && !restart_in && at_limit &&
                     (limit_in != '0);
    end
  end

endmodule : inactivity_timer

// *** drive_power_state_controller.sv ***
/*
 * drive_power_state_controller: tracks active, idle, standby and sleep
 * for an ATA disk drive and gates the voice-coil driver and spindle.
 * Assumes a command front end on the same clock decodes host commands
 * into command classes and holds a command until done is pulsed.
 * Reset pins (hardware and software) arrive from outside the clock
 * domain and are synchronised here.
 * A reset event during a media wake drops that command without done;
 * the front end must offer it again. State, gates and status come
 * from registers; ready is combinational on registered state and is
 * low while done stands, so a held command is never taken twice.
 */
`timescale 1ns/1ns

// Operation
// - exactly four power states: active, idle, standby, sleep
// - active powers every circuit; media commands run without delay
// - power-on completion enters active
// - media command in idle or standby moves to active, then runs
// - in active, reset, query, media or non-media command stays active
// - idle turns off voice-coil driver; media commands take longer
// - idle or idle immediate from active or standby enters idle
// - in idle, reset, idle commands, non-media commands stay idle
// - standby turns off voice-coil driver and stops the spindle
// - media command in standby waits longer than in active or idle
// - standby commands from active or idle enter standby
// - enabled power-down timer expiry enters standby
// - in standby, reset, standby commands, query, non-media stay
// - sleep command enters sleep, the minimum-power state
// - sleep leaves only to standby, only on hardware/software reset
// - sleep ignores every command until a reset
// - six power commands are recognised
module drive_power_state_controller #(
  parameter int TIMER_W = power_state_pkg::TIMER_WIDTH,
  parameter int SPINUP_CNT = power_state_pkg::SPINUP_CYCLES,
  parameter int LOAD_CNT = power_state_pkg::LOAD_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // reset and power-on events from the pins
  input wire logic power_on_done_in,
  input wire logic hard_reset_n_in,
  input wire logic soft_reset_in,
  // host command
  input wire power_state_pkg::host_cmd_s cmd_in,
  output logic cmd_ready_out,
  output power_state_pkg::cmd_resp_s resp_out,
  // automatic power-down
  input wire logic autopd_enable_in,
  input wire logic [TIMER_W-1:0] autopd_limit_in,
  // power gating and status
  output power_state_pkg::power_gate_s gate_out,
  output power_state_pkg::power_state_e state_out,
  output logic powered_up_out
);

  import power_state_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // two flops per pin; only the second stage feeds any logic
  logic [1:0] pon_sync_q;
  logic [1:0] hrst_sync_q;
  logic [1:0] srst_sync_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pon_sync_q <= 2'h0;
      hrst_sync_q <= 2'h0;
      srst_sync_q <= 2'h0;
    end else begin
      pon_sync_q <= {pon_sync_q[0], power_on_done_in};
      hrst_sync_q <= {hrst_sync_q[0], ~hard_reset_n_in};
      srst_sync_q <= {srst_sync_q[0], soft_reset_in};
    end
  end

  // edge detect on the synchronised levels only
  logic hrst_prev_q;
  logic srst_prev_q;
  logic pon_prev_q;
  // prev flops reset low, the idle level of each synchronised signal: no false edge after reset
  wire pon_rise = pon_sync_q[1] && !pon_prev_q;
  wire hrst_event = hrst_sync_q[1] && !hrst_prev_q;
  wire srst_event = srst_sync_q[1] && !srst_prev_q;
  // hardware and software resets act alike on the power state
  wire any_reset = hrst_event || srst_event;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrst_prev_q <= 1'b0;
      srst_prev_q <= 1'b0;
      pon_prev_q <= 1'b0;
    end else begin
      hrst_prev_q <= hrst_sync_q[1];
      srst_prev_q <= srst_sync_q[1];
      pon_prev_q <= pon_sync_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command decode
  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_READY,
    SEQ_WAKE
  } seq_e;

  seq_e seq_q;
  seq_e seq_d;
  power_state_e state_q;
  power_state_e state_d;
  logic [WAKE_WIDTH-1:0] wake_q;
  logic [WAKE_WIDTH-1:0] wake_d;
  logic expired;
  logic powered_q;

  // state and sequencer decode
  wire st_active = (state_q == PWR_ACTIVE);
  wire st_idle = (state_q == PWR_IDLE);
  wire st_standby = (state_q == PWR_STANDBY);
  wire st_sleep = (state_q == PWR_SLEEP);
  wire seq_ready = (seq_q == SEQ_READY);
  wire seq_wake = (seq_q == SEQ_WAKE);

  wire is_idle_cmd = (cmd_in.kind == CMD_IDLE) ||
                     (cmd_in.kind == CMD_IDLE_IMMEDIATE);
  wire is_stby_cmd = (cmd_in.kind == CMD_STANDBY) ||
                     (cmd_in.kind == CMD_STANDBY_IMMEDIATE);
  wire is_sleep_cmd = (cmd_in.kind == CMD_SLEEP);
  wire is_query = (cmd_in.kind == CMD_CHECK_POWER_MODE);
  wire is_media = (cmd_in.kind == CMD_MEDIA);

  // media commands from idle or standby must wait for the mechanics
  wire needs_wake = is_media && !st_active;

  // done stands one cycle while the front end still holds the command;
  // refusing in that cycle keeps one command from running twice
  wire resp_busy = resp_out.done;

  // sleep swallows commands; they complete as ignored
  wire in_sleep = st_sleep;
  wire cmd_here = cmd_in.valid && cmd_ready_out;
  wire cmd_accept = cmd_here && !in_sleep && !needs_wake;
  wire cmd_ignore = cmd_here && in_sleep;
  wire wake_start = cmd_here && !in_sleep && needs_wake;
  wire wake_done = seq_wake && (wake_q == '0);
  // expiry only matters while the spindle still turns
  wire expiry_hit = expired && (st_active || st_idle);

  // spindle spin-up costs more than reloading the voice coil
  wire [WAKE_WIDTH-1:0] wake_spinup = WAKE_WIDTH'(SPINUP_CNT - 1);
  wire [WAKE_WIDTH-1:0] wake_load = WAKE_WIDTH'(LOAD_CNT - 1);
  wire [WAKE_WIDTH-1:0] wake_len = st_standby ? wake_spinup :
                                   wake_load;

  assign cmd_ready_out = seq_ready && !any_reset && !resp_busy;

  //////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_d = state_q;
    seq_d = seq_q;
    wake_d = wake_q;
    case (seq_q)
      SEQ_OFF: begin
        // commands wait and reset events are dropped until power-on completes
        if (pon_rise) begin
          state_d = PWR_ACTIVE;
          seq_d = SEQ_READY;
        end
      end
      SEQ_READY: begin
        if (any_reset) begin
          // reset keeps active, idle, standby; sleep goes to standby
          if (state_q == PWR_SLEEP) begin
            state_d = PWR_STANDBY;
          end
        end else if (wake_start) begin
          seq_d = SEQ_WAKE;
          wake_d = wake_len;
        end else if (cmd_accept) begin
          if (is_sleep_cmd) begin
            state_d = PWR_SLEEP;
          end else if (is_stby_cmd) begin
            state_d = PWR_STANDBY;
          end else if (is_idle_cmd) begin
            state_d = PWR_IDLE;
          end
          // query, non-media and media in active change nothing
        end else if (expiry_hit) begin
          state_d = PWR_STANDBY;
        end
      end
      SEQ_WAKE: begin
        if (any_reset) begin
          // the wake is abandoned; the media command ends without done
          seq_d = SEQ_READY;
        end else if (wake_done) begin
          state_d = PWR_ACTIVE;
          seq_d = SEQ_READY;
        end else begin
          wake_d = wake_q - 1'b1;
        end
      end
      default: begin
        seq_d = SEQ_OFF;
      end
    endcase
  end

  // state starts in standby: nothing spins before power-on completes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= PWR_STANDBY;
      seq_q <= SEQ_OFF;
    end else begin
      state_q <= state_d;
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_q <= '0;
    end else begin
      wake_q <= wake_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // response: media command after wake completes in active
  // any other command reports the mode it found when it was taken
  wire wake_finish = wake_done && !any_reset;
  cmd_resp_s resp_d;

  always_comb begin
    resp_d.done = cmd_accept || cmd_ignore || wake_finish;
    resp_d.ignored = cmd_ignore;
    resp_d.state = wake_finish ? PWR_ACTIVE : state_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_out <= '0;
    end else begin
      resp_out <= resp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power gating
  wire coil_on = powered_q && st_active;
  wire spin_on = powered_q &&
                 (st_active || st_idle || seq_wake);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_out <= '0;
    end else begin
      gate_out.voice_coil_driver_on <= coil_on;
      gate_out.spindle_on <= spin_on;
    end
  end

  // power-on completion latches until the next reset_n_in
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      powered_q <= 1'b0;
    end else if (pon_rise) begin
      powered_q <= 1'b1;
    end
  end

  assign state_out = state_q;
  assign powered_up_out = powered_q;

  //////////////////////////////////////////////////////////////////////
  // automatic power-down timer
  // query does not restart; the timer is held in standby and sleep
  wire restart_cmd = cmd_accept && !is_query;
  wire restart_other = wake_start || any_reset;
  wire timer_restart = restart_cmd || restart_other;
  wire timer_run = seq_ready && (st_active || st_idle);

  inactivity_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(autopd_enable_in),
    .restart_in(timer_restart),
    .run_in(timer_run),
    .limit_in(autopd_limit_in),
    .expired_out(expired)
  );

endmodule : drive_power_state_controller

// *** pwr_chk.sv ***
/* pwr_chk: port assertions for the drive power-state controller.
   assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ns
module pwr_chk
  import power_state_pkg::*;
#(
  parameter int TIMER_W = 32,
  parameter int SPINUP_CNT = 250,
  parameter int LOAD_CNT = 50
) (
  // clock, reset and events
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic power_on_done_in,
  input wire logic hard_reset_n_in,
  input wire logic soft_reset_in,
  // command, timer and status
  input wire power_state_pkg::host_cmd_s cmd_in,
  input wire logic cmd_ready_out,
  input wire power_state_pkg::cmd_resp_s resp_out,
  input wire logic autopd_enable_in,
  input wire logic [TIMER_W-1:0] autopd_limit_in,
  input wire power_state_pkg::power_gate_s gate_out,
  input wire power_state_pkg::power_state_e state_out,
  input wire logic powered_up_out
);
  localparam int WAKE_S = SPINUP_CNT + 2;
  // one-hot of the kind taken this edge, zero when nothing is taken
  wire logic [7:0] tk = (cmd_in.valid && cmd_ready_out) ?
    (8'h01 << cmd_in.kind) : 8'h00;
  wire logic psl = state_out == PWR_SLEEP;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // spin-up must not answer at once, yet must answer in bounded time
  sequence s_wake;
    !resp_out.done ##[1:WAKE_S] (resp_out.done && state_out == PWR_ACTIVE);
  endsequence
  property p_act_gate;
    state_out == PWR_ACTIVE |=> gate_out == 2'h3;
  endproperty
  a_act_gate: assert property (p_act_gate)
    else $error("gates not on in active");
  property p_idle_gate;
    state_out == PWR_IDLE |=> gate_out == 2'h1;
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("idle gates wrong");
  // the spindle may turn in standby only while a media wake holds ready low
  property p_stby_gate;
    state_out == PWR_STANDBY |=> !gate_out.voice_coil_driver_on &&
      (!gate_out.spindle_on || !$past(cmd_ready_out));
  endproperty
  a_stby_gate: assert property (p_stby_gate)
    else $error("standby gates wrong");
  property p_to_idle;
    (tk[CMD_IDLE] || tk[CMD_IDLE_IMMEDIATE]) && !psl
      |=> resp_out.done && state_out == PWR_IDLE;
  endproperty
  a_to_idle: assert property (p_to_idle)
    else $error("idle command missed idle");
  property p_to_stby;
    (tk[CMD_STANDBY] || tk[CMD_STANDBY_IMMEDIATE]) && !psl
      |=> resp_out.done && state_out == PWR_STANDBY;
  endproperty
  a_to_stby: assert property (p_to_stby)
    else $error("standby command missed standby");
  property p_query;
    tk[CMD_CHECK_POWER_MODE] && !psl |=> resp_out.done &&
      resp_out.state == $past(state_out) && $stable(state_out);
  endproperty
  a_query: assert property (p_query)
    else $error("query changed or misreported state");
  property p_sleep_ign;
    psl && tk != 8'h00 |=> resp_out.done && resp_out.ignored && psl;
  endproperty
  a_sleep_ign: assert property (p_sleep_ign)
    else $error("command acted on in sleep");
  property p_wake;
    state_out == PWR_STANDBY && tk[CMD_MEDIA] |=> s_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("media wake from standby wrong");
endmodule : pwr_chk

bind drive_power_state_controller pwr_chk #(.TIMER_W(TIMER_W),
  .SPINUP_CNT(SPINUP_CNT), .LOAD_CNT(LOAD_CNT)) u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in),
  .power_on_done_in(power_on_done_in), .hard_reset_n_in(hard_reset_n_in),
  .soft_reset_in(soft_reset_in), .cmd_in(cmd_in),
  .cmd_ready_out(cmd_ready_out), .resp_out(resp_out),
  .autopd_enable_in(autopd_enable_in), .autopd_limit_in(autopd_limit_in),
  .gate_out(gate_out), .state_out(state_out),
  .powered_up_out(powered_up_out));

// *** host_model.sv ***
/* host_model: host side issuing one command at a time.
   assumes the controller's clock and its hold-until-done handshake. */
`timescale 1ns/1ns
module host_model
  import power_state_pkg::*;
(
  // clock
  input wire logic clk_in,
  // command path
  output power_state_pkg::host_cmd_s cmd_out,
  input wire logic ready_in,
  input wire power_state_pkg::cmd_resp_s resp_in
);
  initial cmd_out = '0;
  task automatic issue(input cmd_kind_e k, output cmd_resp_s r,
    output int n);
    n = -1;
    r = '0;
    cmd_out = '{1'b1, k};
    for (int t = 0; t < 400; t++) begin
      @(posedge clk_in);
      if (n >= 0) begin
        n++;
        if (resp_in.done) begin
          r = resp_in;
          break;
        end
      end else if (ready_in) begin
        n = 0;
      end
    end
    if (!r.done)
      n = -1;
    // stale kind is inverted so nothing leans on a released value
    #1 cmd_out = '{1'b0, cmd_kind_e'(~k)};
  endtask : issue
endmodule : host_model

// *** test_drive_power_state_controller.sv ***
/* test_drive_power_state_controller: random and corner command runs.
   assumes host_model and the bound pwr_chk are compiled alongside. */
`timescale 1ns/1ns
module test_drive_power_state_controller;
  import power_state_pkg::*;
  localparam int SP = 8;
  localparam int LD = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pod = 1'b0;
  logic hrst_n = 1'b1;
  logic srst = 1'b0;
  logic en = 1'b0;
  logic [31:0] lim = 32'h28;
  logic rdy;
  logic pup;
  host_cmd_s cmd;
  cmd_resp_s resp;
  power_gate_s gate;
  power_state_e st;
  power_state_e es;
  int fails = 0;
  int n_checks = 0;
  int i;
  int sd;
  int cl[20] = '{4, 6, 5, 9, 6, 0, 1, 7, 5, 6, 2, 0, 3, 5, 7, 1, 2, 4, 8, 5};
  always #2 clk = ~clk;
  drive_power_state_controller #(.SPINUP_CNT(SP), .LOAD_CNT(LD)) u_dut (
    .clk_in(clk), .reset_n_in(reset_n), .power_on_done_in(pod),
    .hard_reset_n_in(hrst_n), .soft_reset_in(srst), .cmd_in(cmd),
    .cmd_ready_out(rdy), .resp_out(resp), .autopd_enable_in(en),
    .autopd_limit_in(lim), .gate_out(gate), .state_out(st),
    .powered_up_out(pup));
  host_model u_host (.clk_in(clk), .cmd_out(cmd), .ready_in(rdy),
    .resp_in(resp));
  function automatic power_state_e nxt(power_state_e s, cmd_kind_e k);
    if (s == PWR_SLEEP)
      return s;
    case (k)
      CMD_IDLE, CMD_IDLE_IMMEDIATE: return PWR_IDLE;
      CMD_STANDBY, CMD_STANDBY_IMMEDIATE: return PWR_STANDBY;
      CMD_SLEEP: return PWR_SLEEP;
      CMD_MEDIA: return PWR_ACTIVE;
      default: return s;
    endcase
  endfunction : nxt
  // wake cost counts from the taking edge to the done edge
  function automatic logic [7:0] lat(power_state_e s, cmd_kind_e k);
    if (k != CMD_MEDIA || s == PWR_ACTIVE || s == PWR_SLEEP)
      return 8'h01;
    return (s == PWR_IDLE) ? 8'(LD + 1) : 8'(SP + 1);
  endfunction : lat
  function automatic logic [7:0] gx(power_state_e s);
    return (s == PWR_ACTIVE) ? 8'h03 : (s == PWR_IDLE) ? 8'h01 : 8'h00;
  endfunction : gx
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk_st(input string w, input power_state_e e, g);
    n_checks++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s exp %0d got %0d", w, e, g);
    end
  endtask : chk_st
  task automatic chk_b(input string w, input logic [7:0] e, g);
    n_checks++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s exp %0h got %0h", w, e, g);
    end
  endtask : chk_b
  task automatic wait_st(input power_state_e s);
    for (i = 0; i < 80 && st !== s; i++) begin
      @(posedge clk);
      #1;
    end
    chk_st("wait state", s, st);
    if (st !== s)
      wrap_up;
  endtask : wait_st
  task automatic step(input int r);
    cmd_resp_s rs;
    int n;
    cmd_kind_e k;
    power_state_e e;
    power_state_e rp;
    if (r >= 8) begin
      if (r == 8)
        hrst_n = 1'b0;
      else
        srst = 1'b1;
      repeat (2) @(posedge clk);
      #1 hrst_n = 1'b1;
      srst = 1'b0;
      if (es == PWR_SLEEP)
        es = PWR_STANDBY;
      repeat (6) @(posedge clk);
    end else begin
      k = cmd_kind_e'(r);
      e = nxt(es, k);
      u_host.issue(k, rs, n);
      chk_b("latency", lat(es, k), n[7:0]);
      if (n < 0)
        wrap_up;
      // a taken command reports the mode it found; a finished wake, active
      rp = (k == CMD_MEDIA && es != PWR_SLEEP) ? PWR_ACTIVE : es;
      chk_st("reported state", rp, rs.state);
      chk_b("ignored", {7'h0, es == PWR_SLEEP}, {7'h0, rs.ignored});
      es = e;
      @(posedge clk);
    end
    #1;
    chk_st("state", es, st);
    chk_b("gates", gx(es), {6'h0, gate});
  endtask : step
  initial begin
    sd = $urandom(68061);
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    chk_st("reset state", PWR_STANDBY, st);
    @(posedge clk);
    #1 pod = 1'b1;
    wait_st(PWR_ACTIVE);
    chk_b("powered up", 8'h01, {7'h0, pup});
    es = PWR_ACTIVE;
    step(7);
    $display("test power_on done");
    foreach (cl[j])
      step(cl[j]);
    $display("test corners done");
    repeat (80)
      step($urandom % 10);
    $display("test random done");
    step(8);
    en = 1'b1;
    step(0);
    repeat (20) @(posedge clk);
    #1;
    chk_st("before expiry", PWR_IDLE, st);
    wait_st(PWR_STANDBY);
    $display("test autopd done");
    wrap_up;
  end
endmodule : test_drive_power_state_controller
